// [rtl/dcf_arbiter.sv]
// picks the requesting channel of highest priority, lowest number on a tie
`timescale 1ns/100ps
module dcf_arbiter (
   // requests and their priorities
   input wire logic [4:0] req_i,
   input wire logic [9:0] prio_i,
   // winner
   output logic win_valid_o,
   output logic [2:0] win_ch_o
);
   logic [1:0] best;

   // scan downward so the lowest channel wins among equals
   always_comb begin
      win_valid_o = 1'b0;
      win_ch_o = 3'h0;
      best = 2'h0;
      for (int i = 4; i >= 0; i--) begin
         if (req_i[i] && (!win_valid_o || prio_i[2*i +: 2] >= best)) begin // see R9
            win_valid_o = 1'b1;
            win_ch_o = 3'(i);
            best = prio_i[2*i +: 2];
         end
      end
   end
endmodule : dcf_arbiter

// [rtl/dcf_channel.sv]
// one channel: pointers, remaining count and round events
`timescale 1ns/100ps
`include "dcf_defs.svh"
module dcf_channel (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // settings
   input wire logic [14:0] cfg_i,
   input wire logic [15:0] count_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] maddr_i,
   input wire logic periph_req_i,
   // transfer outcome for this channel
   input wire logic done_i,
   input wire logic err_i,
   // state towards the mover
   output logic req_o,
   output logic [31:0] paddr_o,
   output logic [31:0] maddr_o,
   // one-cycle events
   output logic half_evt_o,
   output logic fin_evt_o,
   output logic err_evt_o
);
   dcf_pkg::dcf_ch_state_t state_reg, state_next;
   logic [15:0] remain_reg, remain_next;
   logic [31:0] paddr_reg, paddr_next, maddr_reg, maddr_next;
   logic enable;

   // byte step for one beat; reserved code steps like 32 bits
   function automatic logic [31:0] step_of(input logic [1:0] sz);
      step_of = (sz == 2'h0) ? 32'h1 : (sz == 2'h1) ? 32'h2 : 32'h4;
   endfunction : step_of

   assign enable = cfg_i[`DCF_B_EN];

   // round sequencing
   always_comb begin
      state_next = state_reg;
      remain_next = remain_reg;
      paddr_next = paddr_reg;
      maddr_next = maddr_reg;
      half_evt_o = 1'b0;
      fin_evt_o = 1'b0;
      err_evt_o = 1'b0;
      unique case (state_reg)
         dcf_pkg::CH_IDLE: begin
            if (enable) begin
               remain_next = count_i;
               paddr_next = paddr_i;
               maddr_next = maddr_i;
               state_next = (count_i == 16'h0) ? dcf_pkg::CH_STOP : dcf_pkg::CH_RUN;
            end
         end
         dcf_pkg::CH_RUN: begin
            if (!enable) begin
               state_next = dcf_pkg::CH_IDLE;
            end else if (err_i) begin
               err_evt_o = 1'b1; // see R17
               state_next = dcf_pkg::CH_STOP;
            end else if (done_i) begin
               remain_next = remain_reg - 16'h1;
               if (cfg_i[`DCF_B_MEMORY_POINTER_STEP]) begin
                  maddr_next = maddr_reg + step_of(cfg_i[`DCF_B_MEMORY_ACCESS_WIDTH +: 2]); // see R10, R12
               end
               if (cfg_i[`DCF_B_PERIPHERAL_POINTER_STEP]) begin
                  paddr_next = paddr_reg + step_of(cfg_i[`DCF_B_PERIPHERAL_ACCESS_WIDTH +: 2]); // see R11, R13
               end
               // half point measured against the programmed length
               if (count_i > 16'h1 && remain_next == count_i - (count_i >> 1)) begin
                  half_evt_o = 1'b1; // see R18
               end
               if (remain_next == 16'h0) begin
                  fin_evt_o = 1'b1; // see R19
                  if (cfg_i[`DCF_B_AUTO_RELOAD_MODE]) begin
                     remain_next = count_i; // see R21
                     paddr_next = paddr_i;
                     maddr_next = maddr_i;
                  end else begin
                     state_next = dcf_pkg::CH_STOP; // see R14
                  end
               end
            end
         end
         dcf_pkg::CH_STOP: begin
            if (!enable) begin
               state_next = dcf_pkg::CH_IDLE;
            end
         end
         default: state_next = dcf_pkg::CH_IDLE;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_reg <= dcf_pkg::CH_IDLE;
         remain_reg <= 16'h0;
         paddr_reg <= 32'h0;
         maddr_reg <= 32'h0;
      end else begin
         state_reg <= state_next;
         remain_reg <= remain_next;
         paddr_reg <= paddr_next;
         maddr_reg <= maddr_next;
      end
   end

   // memory copy ignores the peripheral request line
   assign req_o = (state_reg == dcf_pkg::CH_RUN) && enable
                  && (cfg_i[`DCF_B_M2M] || periph_req_i); // see R8
   assign paddr_o = paddr_reg;
   assign maddr_o = maddr_reg;
endmodule : dcf_channel

// [rtl/dcf_defs.svh]
// register offsets, field positions and reset values of the channel block
`ifndef DCF_DEFS_SVH
`define DCF_DEFS_SVH
`define DCF_NUM_CH 5
`define DCF_OFS_STATUS 8'h00
`define DCF_OFS_CLEAR 8'h04
`define DCF_OFS_CH_BASE 8'h08
`define DCF_CH_STRIDE 8'h14
`define DCF_SUB_CFG 2'h0
`define DCF_SUB_COUNT 2'h1
`define DCF_SUB_PADDR 2'h2
`define DCF_SUB_MADDR 2'h3
`define DCF_CFG_MASK 15'h7FFF
`define DCF_CFG_RST 15'h0000
`define DCF_CLEAR_RST 32'h0000_0000
`define DCF_FLAG_MASK 20'hFFFFF
`define DCF_B_EN 0
`define DCF_B_FAULT_IRQ_ENABLE 3
`define DCF_B_DIR 4
`define DCF_B_AUTO_RELOAD_MODE 5
`define DCF_B_PERIPHERAL_POINTER_STEP 6
`define DCF_B_MEMORY_POINTER_STEP 7
`define DCF_B_PERIPHERAL_ACCESS_WIDTH 8
`define DCF_B_MEMORY_ACCESS_WIDTH 10
`define DCF_B_PRIO 12
`define DCF_B_M2M 14
`define DCF_F_GLB 0
`define DCF_F_FIN 1
`define DCF_F_HALF 2
`define DCF_F_FAULT 3
`endif

// [rtl/dcf_pkg.sv]
// types shared by the channel block modules
package dcf_pkg;
   typedef enum logic [1:0] {SZ_8, SZ_16, SZ_32, SZ_RSVD} dcf_size_t;
   typedef enum logic [1:0] {PRIO_LOW, PRIO_MED, PRIO_HIGH, PRIO_VHIGH} dcf_prio_t;
   typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_STOP} dcf_ch_state_t;
   typedef enum logic {MV_IDLE, MV_WAIT} dcf_mv_state_t;
endpackage : dcf_pkg

// [rtl/dcf_top.sv]
// five-channel DMA control: APB registers, event flags and transfer issue
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`include "dcf_defs.svh"
// Functional notes
// R1 - writing one clears channel fault flag
// R2 - writing one clears channel halfway flag
// R3 - writing one clears channel finished flag
// R4 - writing one clears channel summary flag
// R5 - flag clear register resets to zero
// R6 - five setup registers, 0x08 plus 20 each
// R7 - software writes reserved setup bits as zero
// R8 - memory copy mode; change only when disabled
// R9 - two-bit priority; program only when disabled
// R10 - memory access width 8/16/32, 11 reserved
// R11 - peripheral access width 8/16/32, 11 reserved
// R12 - memory pointer steps when enabled
// R13 - peripheral pointer steps when enabled
// R14 - without auto reload, stop after one round
// R15 - direction set: memory to peripheral
// R16 - fault irq raised only when enabled
// R17 - hardware sets fault flag on error
// R18 - hardware sets halfway flag at half
// R19 - hardware sets finished flag at end
// R20 - summary flag set on any event
// R21 - auto reload restarts round by itself
module dcf_top (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // peripheral requests
   input wire logic [4:0] periph_req_i,
   // data mover on the system bus
   output logic mv_valid_o,
   output logic [2:0] mv_channel_o,
   output logic [31:0] mv_src_addr_o,
   output logic [31:0] mv_dst_addr_o,
   output logic [1:0] mv_src_size_o,
   output logic [1:0] mv_dst_size_o,
   input wire logic mv_done_i,
   input wire logic mv_error_i,
   // per channel fault requests
   output logic [4:0] fault_irq_o
);
   localparam int NCH = `DCF_NUM_CH;

   // software state
   logic [14:0] cfg_reg [NCH];
   logic [14:0] cfg_next [NCH];
   logic [15:0] count_reg [NCH];
   logic [15:0] count_next [NCH];
   logic [31:0] pbase_reg [NCH];
   logic [31:0] pbase_next [NCH];
   logic [31:0] mbase_reg [NCH];
   logic [31:0] mbase_next [NCH];
   logic [31:0] flag_clear_reg, flag_clear_next;
   logic [19:0] event_status_reg, event_status_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic [4:0] fault_irq_reg, fault_irq_next;

   // decode results
   logic hit_ch, hit_any;
   logic [2:0] dec_ch;
   logic [1:0] dec_sub;
   logic wr_access;

   // channel side
   logic [4:0] ch_req, ch_done, ch_err, ev_half, ev_fin, ev_err;
   logic [31:0] ch_paddr [NCH];
   logic [31:0] ch_maddr [NCH];
   logic [9:0] prio_bus;
   logic win_valid;
   logic [2:0] win_ch;

   // mover state
   dcf_pkg::dcf_mv_state_t mv_state_reg, mv_state_next;
   logic mv_valid_reg, mv_valid_next;
   logic [2:0] mv_ch_reg, mv_ch_next;
   logic [31:0] mv_src_reg, mv_src_next, mv_dst_reg, mv_dst_next;
   logic [1:0] mv_ssz_reg, mv_ssz_next, mv_dsz_reg, mv_dsz_next;

   // address decode: each channel owns a 20-byte stride of words
   always_comb begin
      hit_ch = 1'b0;
      dec_ch = 3'h0;
      dec_sub = 2'h0;
      for (int i = 0; i < NCH; i++) begin
         for (int s = 0; s < 4; s++) begin
            if (paddr_i == 8'(`DCF_OFS_CH_BASE + 8'(i) * `DCF_CH_STRIDE + 8'(4 * s))) begin
               hit_ch = 1'b1; // see R6
               dec_ch = 3'(i);
               dec_sub = 2'(s);
            end
         end
      end
      hit_any = hit_ch || paddr_i == `DCF_OFS_STATUS || paddr_i == `DCF_OFS_CLEAR;
   end

   // a write lands at the access edge; pready is always high then
   assign wr_access = psel_i && penable_i && pready_reg && pwrite_i;

   // bus answer: prepared in setup, shown during access
   always_comb begin
      pready_next = psel_i && !penable_i;
      pslverr_next = psel_i && !penable_i && !hit_any;
      prdata_next = 32'h0;
      if (psel_i && !penable_i && !pwrite_i) begin
         if (paddr_i == `DCF_OFS_STATUS) begin
            prdata_next = {12'h000, event_status_reg};
         end else if (paddr_i == `DCF_OFS_CLEAR) begin
            prdata_next = flag_clear_reg;
         end else if (hit_ch) begin
            unique case (dec_sub)
               `DCF_SUB_CFG: prdata_next = {17'h00000, cfg_reg[dec_ch]};
               `DCF_SUB_COUNT: prdata_next = {16'h0000, count_reg[dec_ch]};
               `DCF_SUB_PADDR: prdata_next = pbase_reg[dec_ch];
               `DCF_SUB_MADDR: prdata_next = mbase_reg[dec_ch];
            endcase
         end
      end
   end

   // software writable registers; setup bits 15 and up are dropped, unused bits 1 and 2 are kept
   always_comb begin
      flag_clear_next = flag_clear_reg;
      for (int i = 0; i < NCH; i++) begin
         cfg_next[i] = cfg_reg[i];
         count_next[i] = count_reg[i];
         pbase_next[i] = pbase_reg[i];
         mbase_next[i] = mbase_reg[i];
      end
      if (wr_access && paddr_i == `DCF_OFS_CLEAR) begin
         flag_clear_next = {12'h000, pwdata_i[19:0]};
      end
      if (wr_access && hit_ch) begin
         unique case (dec_sub)
            `DCF_SUB_CFG: cfg_next[dec_ch] = pwdata_i[14:0] & `DCF_CFG_MASK; // see R7
            `DCF_SUB_COUNT: count_next[dec_ch] = pwdata_i[15:0];
            `DCF_SUB_PADDR: pbase_next[dec_ch] = pwdata_i;
            `DCF_SUB_MADDR: mbase_next[dec_ch] = pwdata_i;
         endcase
      end
   end

   // event flags: a set in the clearing cycle survives
   always_comb begin
      logic [19:0] clr, set;
      clr = 20'h0;
      set = 20'h0;
      if (wr_access && paddr_i == `DCF_OFS_CLEAR) begin
         clr = pwdata_i[19:0]; // see R1, R2, R3, R4
      end
      for (int i = 0; i < NCH; i++) begin
         set[4*i + `DCF_F_FAULT] = ev_err[i]; // see R17
         set[4*i + `DCF_F_HALF] = ev_half[i]; // see R18
         set[4*i + `DCF_F_FIN] = ev_fin[i]; // see R19
         set[4*i + `DCF_F_GLB] = ev_err[i] | ev_half[i] | ev_fin[i]; // see R20
      end
      event_status_next = ((event_status_reg & ~clr) | set) & `DCF_FLAG_MASK;
      for (int i = 0; i < NCH; i++) begin
         fault_irq_next[i] = event_status_next[4*i + `DCF_F_FAULT]
                             && cfg_reg[i][`DCF_B_FAULT_IRQ_ENABLE]; // see R16
      end
   end

   // one transfer outstanding at a time keeps the mover simple
   always_comb begin
      mv_state_next = mv_state_reg;
      mv_valid_next = mv_valid_reg;
      mv_ch_next = mv_ch_reg;
      mv_src_next = mv_src_reg;
      mv_dst_next = mv_dst_reg;
      mv_ssz_next = mv_ssz_reg;
      mv_dsz_next = mv_dsz_reg;
      ch_done = 5'h0;
      ch_err = 5'h0;
      unique case (mv_state_reg)
         dcf_pkg::MV_IDLE: begin
            if (win_valid) begin
               mv_valid_next = 1'b1;
               mv_ch_next = win_ch;
               mv_state_next = dcf_pkg::MV_WAIT;
               if (cfg_reg[win_ch][`DCF_B_DIR]) begin // see R15
                  mv_src_next = ch_maddr[win_ch];
                  mv_dst_next = ch_paddr[win_ch];
                  mv_ssz_next = cfg_reg[win_ch][`DCF_B_MEMORY_ACCESS_WIDTH +: 2];
                  mv_dsz_next = cfg_reg[win_ch][`DCF_B_PERIPHERAL_ACCESS_WIDTH +: 2];
               end else begin
                  mv_src_next = ch_paddr[win_ch];
                  mv_dst_next = ch_maddr[win_ch];
                  mv_ssz_next = cfg_reg[win_ch][`DCF_B_PERIPHERAL_ACCESS_WIDTH +: 2];
                  mv_dsz_next = cfg_reg[win_ch][`DCF_B_MEMORY_ACCESS_WIDTH +: 2];
               end
            end
         end
         dcf_pkg::MV_WAIT: begin
            if (mv_done_i || mv_error_i) begin
               mv_valid_next = 1'b0;
               mv_state_next = dcf_pkg::MV_IDLE;
               ch_err[mv_ch_reg] = mv_error_i;
               ch_done[mv_ch_reg] = mv_done_i && !mv_error_i;
            end
         end
      endcase
   end

   // all state registers
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NCH; i++) begin
            cfg_reg[i] <= `DCF_CFG_RST;
            count_reg[i] <= 16'h0000;
            pbase_reg[i] <= 32'h0000_0000;
            mbase_reg[i] <= 32'h0000_0000;
         end
         flag_clear_reg <= `DCF_CLEAR_RST; // see R5
         event_status_reg <= 20'h00000;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         fault_irq_reg <= 5'h00;
         mv_state_reg <= dcf_pkg::MV_IDLE;
         mv_valid_reg <= 1'b0;
         mv_ch_reg <= 3'h0;
         mv_src_reg <= 32'h0000_0000;
         mv_dst_reg <= 32'h0000_0000;
         mv_ssz_reg <= 2'h0;
         mv_dsz_reg <= 2'h0;
      end else begin
         cfg_reg <= cfg_next;
         count_reg <= count_next;
         pbase_reg <= pbase_next;
         mbase_reg <= mbase_next;
         flag_clear_reg <= flag_clear_next;
         event_status_reg <= event_status_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         fault_irq_reg <= fault_irq_next;
         mv_state_reg <= mv_state_next;
         mv_valid_reg <= mv_valid_next;
         mv_ch_reg <= mv_ch_next;
         mv_src_reg <= mv_src_next;
         mv_dst_reg <= mv_dst_next;
         mv_ssz_reg <= mv_ssz_next;
         mv_dsz_reg <= mv_dsz_next;
      end
   end

   // five identical channel engines
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      assign prio_bus[2*g +: 2] = cfg_reg[g][`DCF_B_PRIO +: 2];
      dcf_channel u_ch (
         .clock_i(clock_i),
         .rst_n_i(rst_n_i),
         .cfg_i(cfg_reg[g]),
         .count_i(count_reg[g]),
         .paddr_i(pbase_reg[g]),
         .maddr_i(mbase_reg[g]),
         .periph_req_i(periph_req_i[g]),
         .done_i(ch_done[g]),
         .err_i(ch_err[g]),
         .req_o(ch_req[g]),
         .paddr_o(ch_paddr[g]),
         .maddr_o(ch_maddr[g]),
         .half_evt_o(ev_half[g]),
         .fin_evt_o(ev_fin[g]),
         .err_evt_o(ev_err[g])
      );
   end

   dcf_arbiter u_arb (
      .req_i(ch_req),
      .prio_i(prio_bus),
      .win_valid_o(win_valid),
      .win_ch_o(win_ch)
   );

   // outputs straight from flops
   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign mv_valid_o = mv_valid_reg;
   assign mv_channel_o = mv_ch_reg;
   assign mv_src_addr_o = mv_src_reg;
   assign mv_dst_addr_o = mv_dst_reg;
   assign mv_src_size_o = mv_ssz_reg;
   assign mv_dst_size_o = mv_dsz_reg;
   assign fault_irq_o = fault_irq_reg;
endmodule : dcf_top

// [verification/dcf_mover_model.sv]
// behavioural system bus mover answering each beat of the channel block
`timescale 1ns/100ps
module dcf_mover_model (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // request and bench knobs
   input wire logic mv_valid_i,
   input wire logic [3:0] wait_i,
   input wire logic fail_i,
   // one-cycle answer
   output logic mv_done_o,
   output logic mv_error_o
);
   logic [3:0] cnt;
   // answer after wait_i cycles; never pulse while idle, so no stray answer
   always_ff @(posedge clock_i) begin
      mv_done_o <= 1'b0;
      mv_error_o <= 1'b0;
      if (!rst_n_i || !mv_valid_i || mv_done_o || mv_error_o) begin
         cnt <= 4'h0;
      end else if (cnt == wait_i) begin
         mv_done_o <= !fail_i;
         mv_error_o <= fail_i;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule : dcf_mover_model

// [verification/dcf_top_props.sv]
// port assertions of the channel block, bound onto dcf_top
`timescale 1ns/100ps
module dcf_top_props (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // mover and fault requests
   input wire logic mv_valid_o,
   input wire logic [2:0] mv_channel_o,
   input wire logic [31:0] mv_src_addr_o,
   input wire logic [31:0] mv_dst_addr_o,
   input wire logic mv_done_i,
   input wire logic mv_error_i,
   input wire logic [4:0] fault_irq_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // apb answer, zero wait states
   a_ready_next: assert property (psel_i && !penable_i |=> pready_o)
      else $error("pready missing after setup");
   a_ready_access: assert property (pready_o |-> psel_i && penable_i)
      else $error("pready outside access");
   a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
      else $error("read data not idle zero");
   a_unmapped_err: assert property (psel_i && !penable_i && paddr_i == 8'h18
      |=> pslverr_o && prdata_o == 32'h0000_0000) else $error("hole not refused");
   a_mapped_ok: assert property (psel_i && !penable_i && paddr_i <= 8'h14
      && paddr_i[1:0] == 2'b00
      |=> !pslverr_o) else $error("mapped address refused");
   // mover request stands until answered, then drops
   a_valid_holds: assert property (mv_valid_o && !mv_done_i && !mv_error_i |=> mv_valid_o
      && $stable(mv_src_addr_o) && $stable(mv_dst_addr_o) && $stable(mv_channel_o))
      else $error("mover request changed early");
   a_valid_drops: assert property (mv_valid_o && (mv_done_i || mv_error_i) |=> !mv_valid_o)
      else $error("mover request not released");
   a_chan_range: assert property (mv_valid_o |-> mv_channel_o <= 3'h4)
      else $error("channel number out of range");
   // a fault request only rises after an error or a register write
   a_irq_cause: assert property ((fault_irq_o & ~$past(fault_irq_o)) != 5'h00
      |-> $past(mv_valid_o && mv_error_i) || $past(psel_i && penable_i && pwrite_i, 2))
      else $error("fault request without cause");
   a_reset_quiet: assert property (rst_n_i && !$past(rst_n_i)
      |-> !mv_valid_o && !pready_o && fault_irq_o == 5'h00) else $error("outputs live at reset");
   // main scenarios
   c_beat_done: cover property (mv_valid_o && mv_done_i);
   c_beat_err: cover property (mv_valid_o && mv_error_i);
   c_refused: cover property (pready_o && pslverr_o);
endmodule : dcf_top_props

bind dcf_top dcf_top_props props_u (.clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .prdata_o, .pready_o, .pslverr_o, .mv_valid_o, .mv_channel_o, .mv_src_addr_o,
   .mv_dst_addr_o, .mv_done_i, .mv_error_i, .fault_irq_o);

// [verification/dma_channel_config_flags_test.sv]
// self-checking bench of the channel block with a mover model
`timescale 1ns/100ps
module dma_channel_config_flags_test;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [4:0] periph_req_i = 5'h00;
   logic [3:0] mv_wait = 4'h0;
   logic mv_fail = 1'b0;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic mv_valid_o;
   logic [2:0] mv_channel_o;
   logic [31:0] mv_src_addr_o;
   logic [31:0] mv_dst_addr_o;
   logic [1:0] mv_src_size_o;
   logic [1:0] mv_dst_size_o;
   logic mv_done_i;
   logic mv_error_i;
   logic [4:0] fault_irq_o;
   int mismatches = 0;
   int check_count = 0;

   // 200 MHz clock
   always #2.5 clock_i = ~clock_i;

   dcf_top dut_u (.clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .periph_req_i, .mv_valid_o, .mv_channel_o,
      .mv_src_addr_o, .mv_dst_addr_o, .mv_src_size_o, .mv_dst_size_o, .mv_done_i,
      .mv_error_i, .fault_irq_o);
   dcf_mover_model mover_u (.clock_i, .rst_n_i, .mv_valid_i(mv_valid_o), .wait_i(mv_wait),
      .fail_i(mv_fail), .mv_done_o(mv_done_i), .mv_error_o(mv_error_i));

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; idle edge first so two calls never collide
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      // no wait count assumed; only the watchdog ends a hang
      do begin
         @(posedge clock_i);
      end while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk({e, r}, {1'b0, x});
   endtask : rdc

   // waits for one beat, compares addresses and {src,dst} sizes
   task automatic beat(input logic [31:0] s, input logic [31:0] d, input logic [3:0] sz);
      int n;
      n = 0;
      while (mv_valid_o !== 1'b1 && n < 60) begin
         @(posedge clock_i);
         n++;
      end
      chk({mv_src_addr_o, mv_dst_addr_o}, {s, d});
      chk({mv_src_size_o, mv_dst_size_o}, sz);
      while (mv_valid_o === 1'b1 && n < 90) begin
         @(posedge clock_i);
         n++;
      end
   endtask : beat

   // no new beat may start while the channel is stopped
   task automatic quiet();
      int seen;
      seen = 0;
      repeat (20) begin
         @(posedge clock_i);
         if (mv_valid_o !== 1'b0) seen++;
      end
      chk(seen, 0);
   endtask : quiet

   task automatic t_reset_map();
      logic [31:0] r;
      logic e;
      rdc(8'h04, 32'h0000_0000);
      rdc(8'h00, 32'h0000_0000);
      for (int k = 0; k < 5; k++) begin
         rdc(8'h08 + 8'(8'h14 * k), 32'h0000_0000);
      end
      apb(1'b0, 8'h18, 32'h0000_0000, r, e);
      chk({e, r}, {1'b1, 32'h0000_0000});
   endtask : t_reset_map

   // every priority code and size codes 0 to 2, reserved bits written as ones
   task automatic t_setup_fields();
      logic [31:0] v;
      for (int k = 0; k < 5; k++) begin
         v = 32'hFFFF_8000 | 32'(k % 4) << 12 | 32'(k % 3) << 10 | 32'(2 - k % 3) << 8;
         v = v | 32'h0000_40FE;
         wr(8'h08 + 8'(8'h14 * k), v);
         rdc(8'h08 + 8'(8'h14 * k), v & 32'h0000_7FFF);
         wr(8'h08 + 8'(8'h14 * k), 32'h0000_0000);
      end
   endtask : t_setup_fields

   // channel 1: two beats, both pointers stepping, slow mover
   task automatic t_round();
      mv_wait <= 4'hF;
      periph_req_i <= 5'h01;
      wr(8'h0C, 32'h0000_0002);
      wr(8'h10, 32'h4000_0000);
      wr(8'h14, 32'h2000_0000);
      wr(8'h08, 32'h0000_06C1);
      beat(32'h4000_0000, 32'h2000_0000, 4'h9);
      chk(mv_channel_o, 3'h0);
      rdc(8'h00, 32'h0000_0005);
      beat(32'h4000_0004, 32'h2000_0002, 4'h9);
      quiet();
      rdc(8'h00, 32'h0000_0007);
      wr(8'h08, 32'h0000_0000);
      periph_req_i <= 5'h00;
      mv_wait <= 4'h0;
   endtask : t_round

   task automatic t_clear();
      wr(8'h04, 32'h0000_0000);
      rdc(8'h00, 32'h0000_0007);
      wr(8'h04, 32'h0000_0004);
      rdc(8'h00, 32'h0000_0003);
      wr(8'h04, 32'h0000_0002);
      rdc(8'h00, 32'h0000_0001);
      wr(8'h04, 32'h0000_0001);
      rdc(8'h00, 32'h0000_0000);
   endtask : t_clear

   // channel 2: memory to peripheral, fault with request enabled
   task automatic t_fault();
      mv_fail <= 1'b1;
      periph_req_i <= 5'h02;
      wr(8'h20, 32'h0000_0003);
      wr(8'h24, 32'h4000_0100);
      wr(8'h28, 32'h2000_0100);
      wr(8'h1C, 32'h0000_0419);
      beat(32'h2000_0100, 32'h4000_0100, 4'h4);
      chk(mv_channel_o, 3'h1);
      quiet();
      rdc(8'h00, 32'h0000_0090);
      chk(fault_irq_o, 5'h02);
      wr(8'h04, 32'h0000_0080);
      rdc(8'h00, 32'h0000_0010);
      chk(fault_irq_o, 5'h00);
      wr(8'h1C, 32'h0000_0000);
      periph_req_i <= 5'h00;
      wr(8'h04, 32'h0000_0010);
   endtask : t_fault

   // channel 3: memory copy runs with no peripheral request
   task automatic t_copy();
      wr(8'h34, 32'h0000_0001);
      wr(8'h38, 32'h4000_0200);
      wr(8'h3C, 32'h2000_0200);
      wr(8'h30, 32'h0000_4001);
      beat(32'h4000_0200, 32'h2000_0200, 4'h0);
      chk(mv_channel_o, 3'h2);
      rdc(8'h00, 32'h0000_0900);
      chk(fault_irq_o, 5'h00);
      wr(8'h30, 32'h0000_0000);
      wr(8'h04, 32'h0000_0F00);
   endtask : t_copy

   // channel 4: auto reload repeats the round until a fault stops it
   task automatic t_reload();
      mv_fail <= 1'b0;
      periph_req_i <= 5'h08;
      wr(8'h48, 32'h0000_0001);
      wr(8'h4C, 32'h4000_0300);
      wr(8'h50, 32'h2000_0300);
      // memory step on, so only the reload brings the pointer back
      wr(8'h44, 32'h0000_00A1);
      beat(32'h4000_0300, 32'h2000_0300, 4'h0);
      mv_fail <= 1'b1;
      beat(32'h4000_0300, 32'h2000_0300, 4'h0);
      quiet();
      chk(mv_channel_o, 3'h3);
      rdc(8'h00, 32'h0000_B000);
      wr(8'h44, 32'h0000_0000);
   endtask : t_reload

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   // main sequence
   initial begin
      repeat (8) @(posedge clock_i);
      rst_n_i <= 1'b1;
      t_reset_map();
      t_setup_fields();
      t_round();
      t_clear();
      t_fault();
      t_copy();
      t_reload();
      test_done();
   end

   // watchdog at 20000 cycles, far beyond the few hundred cycles the tests need
   initial begin
      #(5 * 20000);
      mismatches++;
      test_done();
   end
endmodule : dma_channel_config_flags_test
